// ==== didf_filter.sv ====
// Purpose: two-sample agreement filter, one bit per input
// Assumes: tick is a one-cycle pulse once per sample period
// Notes: a new level needs two equal samples in a row
`timescale 1ns/1ps
module didf_filter #(
   parameter int unsigned n = 6
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // sample stream
   didf_samp_if.flt samp
);
   logic [n-1:0] prev;
   logic [n-1:0] acc;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev <= '0;
      end else if (samp.tick) begin
         prev <= samp.sample;
      end
   end

   // a bit moves only when two consecutive samples agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc <= '0;
      end else if (samp.tick) begin
         acc <= (samp.sample & ~(prev ^ samp.sample)) | (acc & (prev ^ samp.sample));
      end
   end

   assign samp.accepted = acc;
endmodule

// ==== didf_monitor.sv ====
// Purpose: port checks for didf_top
// Assumes: tick_period of at least 9
// Notes: bound into every didf_top
`timescale 1ns/1ps
module didf_monitor #(parameter int unsigned tick_period = 10) (
   input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic [5:0] input_debounced_status
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_one_wait: assert property ($rose(penable) && psel |=> pready) else $error("late");
   a_ready_single: assert property (pready |=> !pready) else $error("long ready");
   a_ready_cause: assert property ($rose(pready) |-> $past(psel && penable)) else $error("cause");
   a_idle_data_zero: assert property (!pready |-> prdata == 32'h0000_0000) else $error("idle");
   a_err_unmapped: assert property (pready && paddr > 12'h008 |-> pslverr) else $error("no err");
   a_err_mapped: assert property (pready && paddr < 12'h009 && paddr[1:0] == 2'h0
      |-> !pslverr) else $error("err");
   a_status_upper: assert property (
      pready && paddr == 12'h000 |-> prdata[31:6] == 26'h000_0000) else $error("upper");
   a_status_read: assert property (
      pready && !pwrite && paddr == 12'h000
      |-> prdata[5:0] == $past(input_debounced_status)) else $error("read");
   a_status_hold: assert property (
      $changed(input_debounced_status)
      |=> $stable(input_debounced_status)[*8]) else $error("fast");
   a_reset_status: assert property (
      $rose(presetn) |-> input_debounced_status == 6'h00) else $error("reset");
   c_write: cover property (pready && pwrite);
   c_error: cover property (pslverr);
   c_change: cover property ($changed(input_debounced_status));
endmodule
//////////////////////
bind didf_top didf_monitor #(.tick_period(tick_period)) i_didf_monitor (.pclk, .presetn, .psel,
   .penable, .pwrite, .pready, .pslverr, .paddr, .prdata, .input_debounced_status);

// ==== didf_pkg.sv ====
// Purpose: shared constants for the digital input debounce and force block
// Assumes: 32-bit apb data, one aligned word per register
// Notes: reserved bits of every register read as zero
package didf_pkg;
   localparam int unsigned num_inputs = 6;
   localparam int unsigned reg_width = 16;
   localparam logic [11:0] off_status = 12'h000;
   localparam logic [11:0] off_mask = 12'h004;
   localparam logic [11:0] off_values = 12'h008;
   localparam logic [5:0] mask_reset = 6'h00;
   localparam logic [5:0] values_reset = 6'h00;
   localparam logic [5:0] status_reset = 6'h00;
   localparam int unsigned clk_hz = 50_000_000;
   localparam int unsigned tick_us = 1000;
   localparam int unsigned tick_cycles = (clk_hz / 1_000_000) * tick_us;
   localparam int unsigned stable_samples = 2;
   localparam int unsigned delay_ms = 2;
endpackage

// ==== didf_samp_if.sv ====
// Purpose: carries the sample tick and the forced sample into the filter
// Assumes: single clock domain
// Notes: none
`timescale 1ns/1ps
interface didf_samp_if #(parameter int unsigned n = 6);
   logic tick;
   logic [n-1:0] sample;
   logic [n-1:0] accepted;
   modport src (output tick, output sample, input accepted);
   modport flt (input tick, input sample, output accepted);
endinterface

// ==== didf_terminals.sv ====
// Purpose: six input terminals
// Assumes: levels set by the bench
// Notes: bounce flips every pin, like contact chatter
`timescale 1ns/1ps
module didf_terminals (
   input wire logic [5:0] level,
   input wire logic bounce,
   output logic [5:0] pins
);
   assign pins = bounce ? ~level : level;
endmodule

// ==== didf_top.sv ====
// Purpose: six digital inputs with debounce, software override and apb registers
// Assumes: inputs synchronous to pclk; 50 MHz clock gives a 1 ms tick
// Notes: status 0x000, override mask 0x004, override values 0x008
`timescale 1ns/1ps
module didf_top #(
   parameter int unsigned tick_period = didf_pkg::tick_cycles
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // input terminals
   input wire logic input_one,
   input wire logic input_two,
   input wire logic input_three,
   input wire logic input_four,
   input wire logic input_five,
   input wire logic input_six,
   // debounced state
   output logic [5:0] input_debounced_status
);
   localparam int unsigned n = didf_pkg::num_inputs;

   // bus handshake: the answer comes one cycle after the first access edge
   typedef enum {
      bus_idle,
      bus_answer
   } didf_bus_state_t;

   // override registers
   logic [n-1:0] input_override_mask;
   logic [n-1:0] input_override_values;
   // sample path
   logic [n-1:0] raw;
   logic [n-1:0] sample;
   logic [15:0] tick_cnt;
   logic tick_due;
   logic tick;
   // bus decode
   logic access;
   logic answer_next;
   logic wr;
   logic hit_status;
   logic hit_mask;
   logic hit_values;
   logic mapped;
   logic [31:0] next_prdata;
   didf_bus_state_t bus_state;
   didf_bus_state_t next_bus_state;

   didf_samp_if #(.n(n)) samp ();

   ////////////////////////////////////////////////////////////////////////////
   // input terminals
   // bit order follows the status word: input_one lands in bit 0
   assign raw = {
      input_six,
      input_five,
      input_four,
      input_three,
      input_two,
      input_one
   };

   ////////////////////////////////////////////////////////////////////////////
   // sample tick
   // counter runs free so the sample grid is independent of bus activity
   assign tick_due = (tick_cnt == 16'(tick_period - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt <= 16'h0000;
      end else if (tick_due) begin
         tick_cnt <= 16'h0000;
      end else begin
         tick_cnt <= tick_cnt + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick <= 1'b0;
      end else begin
         tick <= tick_due;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // forcing
   // forcing is applied ahead of the filter, so forced edges see the same delay
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample <= '0;
      end else begin
         sample <= (raw & ~input_override_mask) |
            (input_override_values & input_override_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // debounce filter
   assign samp.tick = tick;
   assign samp.sample = sample;

   didf_filter #(.n(n)) u_filter (
      .pclk(pclk),
      .presetn(presetn),
      .samp(samp)
   );

   // registered again so the port comes straight from a flip-flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_debounced_status <= didf_pkg::status_reset;
      end else begin
         input_debounced_status <= samp.accepted;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   assign access = psel && penable;
   assign answer_next = (bus_state == bus_idle) && access;
   // writes land at the edge where the master sees pready high
   assign wr = (bus_state == bus_answer) && access && pwrite;
   assign hit_status = (paddr == didf_pkg::off_status);
   assign hit_mask = (paddr == didf_pkg::off_mask);
   assign hit_values = (paddr == didf_pkg::off_values);
   assign mapped = hit_status || hit_mask || hit_values;

   ////////////////////////////////////////////////////////////////////////////
   // apb handshake
   always_comb begin
      next_bus_state = bus_state;
      unique case (bus_state)
         bus_idle: begin
            if (access) begin
               next_bus_state = bus_answer;
            end
         end
         bus_answer: begin
            next_bus_state = bus_idle;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_state <= bus_idle;
      end else begin
         bus_state <= next_bus_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // override registers
   // status writes are dropped without an error, the word is read-only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_override_mask <= didf_pkg::mask_reset;
      end else if (wr && hit_mask) begin
         input_override_mask <= pwdata[n-1:0];
      end
   end

   // values may be written while unmasked; they act only once selected
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_override_values <= didf_pkg::values_reset;
      end else if (wr && hit_values) begin
         input_override_values <= pwdata[n-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data
   // status is read from the port register so software and pins agree
   always_comb begin
      next_prdata = 32'h0000_0000;
      if (!pwrite && hit_status) begin
         next_prdata = {26'h000_0000, input_debounced_status};
      end else if (!pwrite && hit_mask) begin
         next_prdata = {26'h000_0000, input_override_mask};
      end else if (!pwrite && hit_values) begin
         next_prdata = {26'h000_0000, input_override_values};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= answer_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= answer_next && !mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= answer_next ? next_prdata : 32'h0000_0000;
      end
   end
endmodule

// ==== didf_top_tb_top.sv ====
// Purpose: self-checking bench for didf_top
// Assumes: tick_period 10, one sample every 10 clocks
// Notes: status = raw outside the mask, forced value inside
`timescale 1ns/1ps
module didf_top_tb_top;
   localparam int unsigned tp = 10;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic pready, pslverr, bounce = 1'b0;
   logic [5:0] level = 6'h00, pins, status;
   int failures = 0, total_checks = 0;
   always #10 pclk = ~pclk;
   didf_terminals i_didf_terminals (.level, .bounce, .pins);
   didf_top #(.tick_period(tp)) i_didf_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .input_one(pins[0]), .input_two(pins[1]),
      .input_three(pins[2]), .input_four(pins[3]), .input_five(pins[4]),
      .input_six(pins[5]), .input_debounced_status(status));
   //////////////////////
   task automatic report_and_stop;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic ex);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(r, x);
      chk({31'h0000_0000, e}, {31'h0000_0000, ex});
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      chk({31'h0000_0000, e}, 32'h0000_0000);
   endtask
   task automatic t_debounce;
      bounce <= 1'b1;
      @(posedge pclk);
      bounce <= 1'b0;
      repeat (3 * tp) @(posedge pclk);
      chk(status, 32'h0000_0000);
      level <= 6'h13;
      repeat (5) @(posedge pclk);
      chk(status, 32'h0000_0000);
      repeat (3 * tp) @(posedge pclk);
      rd(12'h000, 32'h0000_0013, 1'b0);
   endtask
   task automatic t_force;
      wr(12'h008, 32'hFFFF_FFC5);
      wr(12'h004, 32'h0000_000F);
      wr(12'h000, 32'h0000_003F);
      rd(12'h008, 32'h0000_0005, 1'b0);
      rd(12'h00C, 32'h0000_0000, 1'b1);
      repeat (3 * tp) @(posedge pclk);
      chk(status, 32'h0000_0015);
      wr(12'h004, 32'h0000_003F);
      repeat (3 * tp) @(posedge pclk);
      chk(status, 32'h0000_0005);
   endtask
   task automatic t_reset_clears;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h004, 32'h0000_0000, 1'b0);
      rd(12'h008, 32'h0000_0000, 1'b0);
      repeat (3 * tp) @(posedge pclk);
      chk(status, 32'h0000_0013);
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h004, 32'h0000_0000, 1'b0);
      t_debounce;
      t_force;
      t_reset_clears;
      report_and_stop;
   end
   initial begin
      repeat (3000) @(posedge pclk);
      failures++;
      report_and_stop;
   end
endmodule
